/* rtl/egress_sched_pkg.sv */
// Constants for the per-port egress queue scheduler and shaper
// Summary of operation
// - Rotation sends at most weight packets per queue while another queue is eligible
// - Weights ignored with a single egress queue
// - Every queue weight resets to one
// - Queue settings indexed by the queue index
// - Credit high mark, 16 bits, reset 0x0534
// - Credit low mark, 16 bits, reset 0x05F2
// - Credit increment, 16 bits, reset 0x2000
// - Cut-through enable bit, resets to zero
// - Restricted gating holds traffic until open
// - Reference select picks gate cycle start
// - Entry event code: repeat, open, guard, closed
// - Entry time is 29-bit clock cycle count
// - Drop mode 00 drops nothing, asserts flow control
// - Modes 01-11 drop low priorities, no flow control
// - Two-bit queue index selects indexed registers
// - Scheduler mode: strict priority or rotation
// - Shaper mode: none, credit, gate schedule
package egress_sched_pkg;

  // ==========================================================
  // Register indices; the byte address is four times the index
  localparam logic [11:0] QUEUE_INDEX_IDX       = 12'h0900;
  localparam logic [11:0] QUEUE_MODE_IDX        = 12'h0914;
  localparam logic [11:0] QUEUE_WEIGHT_IDX      = 12'h0915;
  localparam logic [11:0] CREDIT_HIGH_MARK_IDX  = 12'h0916;
  localparam logic [11:0] CREDIT_LOW_MARK_IDX   = 12'h0918;
  localparam logic [11:0] CREDIT_INCREMENT_IDX  = 12'h091a;
  localparam logic [11:0] GATE_SHAPER_CTRL_IDX  = 12'h0920;
  localparam logic [11:0] GATE_ENTRY_INDEX_IDX  = 12'h0923;
  localparam logic [11:0] GATE_ENTRY_IDX        = 12'h0924;
  localparam logic [11:0] CONGESTION_DROP_IDX   = 12'h0a00;
  localparam logic [11:0] PORT_STATUS_IDX       = 12'h0a10;

  // ==========================================================
  // Reset values
  localparam logic [6:0]  WEIGHT_RST      = 7'h01;
  localparam logic [15:0] HIGH_MARK_RST   = 16'h0534;
  localparam logic [15:0] LOW_MARK_RST    = 16'h05f2;
  localparam logic [15:0] INCREMENT_RST   = 16'h2000;
  localparam logic [1:0]  SCHED_MODE_RST  = 2'h2;

  // ==========================================================
  // Field positions
  localparam int CUT_THROUGH_BIT   = 7;
  localparam int RESTRICTED_BIT    = 6;
  localparam int EVENT_CODE_MSB    = 31;
  localparam int EVENT_CODE_LSB    = 29;
  localparam int EVENT_TIME_MSB    = 28;
  localparam int SCHED_MODE_LSB    = 6;
  localparam int SHAPER_MODE_LSB   = 4;

  // ==========================================================
  // Encodings
  localparam logic [1:0] SCHED_STRICT   = 2'h0;
  localparam logic [1:0] SCHED_ROTATION = 2'h2;
  localparam logic [1:0] SHAPE_NONE     = 2'h0;
  localparam logic [1:0] SHAPE_CREDIT   = 2'h1;
  localparam logic [1:0] SHAPE_GATE     = 2'h2;
  localparam logic [1:0] REF_NONE       = 2'h0;
  localparam logic [1:0] REF_INTERNAL   = 2'h1;
  localparam logic [1:0] REF_PPS        = 2'h2;
  localparam logic [1:0] REF_CROSS      = 2'h3;
  localparam logic [2:0] EV_CLOSED      = 3'h0;
  localparam logic [2:0] EV_GUARD       = 3'h1;
  localparam logic [2:0] EV_OPEN        = 3'h2;
  localparam logic [2:0] EV_REPEAT      = 3'h7;

  // ==========================================================
  // Timing: internal one-second pulse at the 10 MHz core clock
  localparam longint SECOND_NS      = 1000000000;
  localparam longint CLK_PERIOD_NS  = 100;
  localparam int     SECOND_CYCLES  = int'(SECOND_NS / CLK_PERIOD_NS);

endpackage : egress_sched_pkg

/* rtl/port_egress_queue_scheduler.sv */
// Egress queue scheduler, credit shaper and gate schedule for one port
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ns
module port_egress_queue_scheduler #(
  parameter int NUM_ENTRIES   = 128,
  parameter int SECOND_CYCLES = egress_sched_pkg::SECOND_CYCLES
) (
  // Clock, reset, enable
  input  wire logic        i_core_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_clk_en,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [13:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Fabric queues
  input  wire logic [3:0]  i_queue_nonempty,
  input  wire logic [3:0]  i_queue_gated,
  input  wire logic [3:0]  i_queue_cut_through,
  input  wire logic [1:0]  i_queue_count_sel,
  // Transmit MAC
  input  wire logic        i_tx_ready,
  input  wire logic        i_tx_done,
  input  wire logic [15:0] i_tx_bytes,
  output logic             o_tx_valid,
  output logic [1:0]       o_tx_queue,
  // Time references (from pins / other domains)
  input  wire logic        i_pps,
  input  wire logic        i_ref_crossed,
  // Congestion policy
  input  wire logic        i_dest_congested,
  output logic [3:0]       o_drop_prio,
  output logic             o_flow_control,
  output logic             o_gate_open
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [31:0]      rdata;
    logic             ready;
    logic             err;
    logic [1:0]       qidx;
    logic [3:0][1:0]  sched_mode;
    logic [3:0][1:0]  shaper_mode;
    logic [3:0][6:0]  weight;
    logic [3:0][15:0] high_mark;
    logic [3:0][15:0] low_mark;
    logic [3:0][15:0] increment;
    logic [3:0][16:0] credit;
    logic             cut_through;
    logic             restricted;
    logic [1:0]       ref_sel;
    logic [6:0]       eidx;
    logic [1:0]       drop_mode;
    logic             single_queue;
    logic [1:0]       cur_q;
    logic [6:0]       sent;
    logic             busy;
    logic [6:0]       gptr;
    logic [28:0]      gcnt;
    logic [2:0]       gstate;
    logic             running;
    logic [31:0]      sec_cnt;
    logic [1:0]       pps_s;
    logic [1:0]       cross_s;
    logic             pps_d;
    logic             cross_d;
    logic             tx_valid;
    logic [1:0]       tx_q;
    logic [3:0]       drop;
    logic             fc;
  } state_t;

  state_t     s_r;
  state_t     s_nxt;
  logic [31:0] entry_mem [NUM_ENTRIES];

  // ==========================================================
  // Helpers
  function automatic logic [11:0] reg_of(input logic [13:0] a);
    reg_of = a[13:2];
  endfunction : reg_of

  function automatic logic [1:0] next_q(input logic [1:0] q,
                                        input logic [3:0] elig);
    logic [1:0] c;
    next_q = q;
    for (int k = 1; k <= 4; k++) begin
      c = 2'(q - 2'(k));
      if (elig[c] && next_q == q) begin
        next_q = c;
      end
    end
    if (!elig[q] && next_q == q) begin
      next_q = q;
    end
  endfunction : next_q

  logic        access;
  logic        wr;
  logic [11:0] ridx;
  logic [3:0]  eligible;
  logic [31:0] entry_rd;
  logic [2:0]  cur_code;
  logic [28:0] cur_time;
  logic        start_pulse;
  logic        qsel_strict;
  logic [1:0]  pick;
  logic        pick_ok;
  logic [16:0] credit_left;
  logic [16:0] credit_floor;

  assign access   = psel && penable && i_clk_en;
  assign wr       = access && pwrite;
  assign ridx     = reg_of(paddr);
  assign entry_rd = entry_mem[s_r.eidx];
  assign cur_code = entry_mem[s_r.gptr][egress_sched_pkg::EVENT_CODE_MSB:
                                        egress_sched_pkg::EVENT_CODE_LSB];
  assign cur_time = entry_mem[s_r.gptr][egress_sched_pkg::EVENT_TIME_MSB:0];
  assign credit_left  = 17'(s_r.credit[s_r.tx_q] - {1'b0, i_tx_bytes});
  assign credit_floor = 17'(17'h0_0000 - {1'b0, s_r.low_mark[s_r.tx_q]});

  always_comb begin
    unique case (s_r.ref_sel)
      egress_sched_pkg::REF_NONE:     start_pulse = !s_r.running;
      egress_sched_pkg::REF_INTERNAL:
        start_pulse = (s_r.sec_cnt == 32'(SECOND_CYCLES - 1));
      egress_sched_pkg::REF_PPS:      start_pulse = s_r.pps_s[1] && !s_r.pps_d;
      egress_sched_pkg::REF_CROSS:
        start_pulse = s_r.cross_s[1] && !s_r.cross_d && !s_r.running;
    endcase
  end

  // eligibility: gating and credit per queue
  always_comb begin
    for (int q = 0; q < 4; q++) begin
      eligible[q] = i_queue_nonempty[q];
      if (s_r.shaper_mode[q] == egress_sched_pkg::SHAPE_CREDIT &&
          s_r.credit[q][16]) begin
        eligible[q] = 1'b0;
      end
      if (s_r.shaper_mode[q] == egress_sched_pkg::SHAPE_GATE &&
          i_queue_gated[q] && s_r.restricted &&
          s_r.gstate != egress_sched_pkg::EV_OPEN) begin
        eligible[q] = 1'b0;
      end
      if (i_queue_cut_through[q] && !s_r.cut_through) begin
        eligible[q] = 1'b0;
      end
    end
    if (s_r.single_queue) begin
      eligible[3:1] = 3'b000;
    end
  end

  // strict priority picks highest eligible queue
  always_comb begin
    qsel_strict = (s_r.sched_mode[0] != egress_sched_pkg::SCHED_ROTATION);
    pick        = 2'h0;
    pick_ok     = |eligible;
    if (qsel_strict || s_r.single_queue) begin
      for (int q = 0; q < 4; q++) begin
        if (eligible[q]) begin
          pick = 2'(q);
        end
      end
    end else if (eligible[s_r.cur_q] &&
                 s_r.sent < s_r.weight[s_r.cur_q]) begin
      pick = s_r.cur_q;
    end else begin
      pick = next_q(s_r.cur_q, eligible);
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    s_nxt       = s_r;
    s_nxt.ready = 1'b0;
    s_nxt.err   = 1'b0;
    s_nxt.pps_s   = {s_r.pps_s[0], i_pps};
    s_nxt.cross_s = {s_r.cross_s[0], i_ref_crossed};
    s_nxt.pps_d   = s_r.pps_s[1];
    s_nxt.cross_d = s_r.cross_s[1];
    s_nxt.sec_cnt = (s_r.sec_cnt == 32'(SECOND_CYCLES - 1)) ? 32'h0000_0000
                    : s_r.sec_cnt + 32'h0000_0001;

    // APB access, answered one cycle after penable rises (one wait state)
    if (access && !s_r.ready) begin
      s_nxt.ready = 1'b1;
      s_nxt.rdata = 32'h0000_0000;
      unique case (ridx)
        egress_sched_pkg::QUEUE_INDEX_IDX: begin
          s_nxt.rdata = {30'h0000_0000, s_r.qidx};
          if (wr) s_nxt.qidx = pwdata[1:0];
        end
        egress_sched_pkg::QUEUE_MODE_IDX: begin
          s_nxt.rdata = {24'h00_0000, s_r.sched_mode[s_r.qidx],
                         s_r.shaper_mode[s_r.qidx], 4'h0};
          if (wr) begin
            s_nxt.sched_mode[s_r.qidx]  = pwdata[7:6];
            s_nxt.shaper_mode[s_r.qidx] = pwdata[5:4];
          end
        end
        egress_sched_pkg::QUEUE_WEIGHT_IDX: begin
          s_nxt.rdata = {25'h000_0000, s_r.weight[s_r.qidx]};
          if (wr) s_nxt.weight[s_r.qidx] = pwdata[6:0];
        end
        egress_sched_pkg::CREDIT_HIGH_MARK_IDX: begin
          s_nxt.rdata = {16'h0000, s_r.high_mark[s_r.qidx]};
          if (wr) s_nxt.high_mark[s_r.qidx] = pwdata[15:0];
        end
        egress_sched_pkg::CREDIT_LOW_MARK_IDX: begin
          s_nxt.rdata = {16'h0000, s_r.low_mark[s_r.qidx]};
          if (wr) s_nxt.low_mark[s_r.qidx] = pwdata[15:0];
        end
        egress_sched_pkg::CREDIT_INCREMENT_IDX: begin
          s_nxt.rdata = {16'h0000, s_r.increment[s_r.qidx]};
          if (wr) s_nxt.increment[s_r.qidx] = pwdata[15:0];
        end
        egress_sched_pkg::GATE_SHAPER_CTRL_IDX: begin
          s_nxt.rdata = {24'h00_0000, s_r.cut_through, s_r.restricted,
                         4'h0, s_r.ref_sel};
          if (wr) begin
            s_nxt.cut_through = pwdata[egress_sched_pkg::CUT_THROUGH_BIT];
            s_nxt.restricted  = pwdata[egress_sched_pkg::RESTRICTED_BIT];
            s_nxt.ref_sel     = pwdata[1:0];
            s_nxt.running     = 1'b0;
          end
        end
        egress_sched_pkg::GATE_ENTRY_INDEX_IDX: begin
          s_nxt.rdata = {25'h000_0000, s_r.eidx};
          if (wr) s_nxt.eidx = pwdata[6:0];
        end
        egress_sched_pkg::GATE_ENTRY_IDX: begin
          s_nxt.rdata = entry_rd;
        end
        egress_sched_pkg::CONGESTION_DROP_IDX: begin
          s_nxt.rdata = {30'h0000_0000, s_r.drop_mode};
          if (wr) s_nxt.drop_mode = pwdata[1:0];
        end
        egress_sched_pkg::PORT_STATUS_IDX: begin
          s_nxt.rdata = {16'h0000, s_r.gstate, s_r.gptr,
                         s_r.running, s_r.single_queue, 2'b00, s_r.cur_q};
          if (wr) s_nxt.single_queue = pwdata[4];
        end
        default: begin
          s_nxt.err = 1'b1;
        end
      endcase
    end

    if (start_pulse) begin
      s_nxt.running = 1'b1;
      s_nxt.gptr    = 7'h00;
      s_nxt.gcnt    = 29'h0000_0000;
    end else if (s_r.running) begin
      if (s_r.gcnt >= cur_time) begin
        s_nxt.gcnt = 29'h0000_0000;
        unique case (cur_code)
          egress_sched_pkg::EV_REPEAT: s_nxt.gptr = 7'h00;
          egress_sched_pkg::EV_OPEN,
          egress_sched_pkg::EV_GUARD,
          egress_sched_pkg::EV_CLOSED: begin
            s_nxt.gstate = cur_code;
            s_nxt.gptr   = 7'(s_r.gptr + 7'h01);
          end
          default: s_nxt.gptr = 7'(s_r.gptr + 7'h01);
        endcase
      end else begin
        s_nxt.gcnt = 29'(s_r.gcnt + 29'h0000_0001);
      end
    end

    // Credit: gain one eighth of increment per cycle while waiting, bounded by marks
    for (int q = 0; q < 4; q++) begin
      if (s_r.shaper_mode[q] == egress_sched_pkg::SHAPE_CREDIT) begin
        if (i_queue_nonempty[q] && !s_r.credit[q][16] &&
            s_r.credit[q][15:0] >= s_r.high_mark[q]) begin
          s_nxt.credit[q] = {1'b0, s_r.high_mark[q]};
        end else if (i_queue_nonempty[q]) begin
          s_nxt.credit[q] = 17'(s_r.credit[q] + {4'h0, s_r.increment[q][15:3]});
        end else if (!s_r.credit[q][16]) begin
          s_nxt.credit[q] = 17'h0_0000;
        end
      end else begin
        s_nxt.credit[q] = 17'h0_0000;
      end
    end

    // Transmit grant: one packet at a time
    if (!s_r.busy && pick_ok && i_tx_ready) begin
      s_nxt.tx_valid = 1'b1;
      s_nxt.tx_q     = pick;
      s_nxt.busy     = 1'b1;
      if (pick == s_r.cur_q) begin
        s_nxt.sent = 7'(s_r.sent + 7'h01);
      end else begin
        s_nxt.sent = 7'h01;
      end
      s_nxt.cur_q = pick;
    end else begin
      s_nxt.tx_valid = 1'b0;
    end
    if (s_r.busy && i_tx_done) begin
      s_nxt.busy = 1'b0;
      if (s_r.shaper_mode[s_r.tx_q] == egress_sched_pkg::SHAPE_CREDIT) begin
        // spent credit floors at minus the low mark
        s_nxt.credit[s_r.tx_q] = credit_left;
        if (credit_left[16] &&
            (!credit_floor[16] || credit_left < credit_floor)) begin
          s_nxt.credit[s_r.tx_q] = credit_floor;
        end
      end
    end

    s_nxt.fc   = i_dest_congested &&
                 (s_r.drop_mode == 2'h0);
    unique case (s_r.drop_mode)
      2'h0: s_nxt.drop = 4'h0;
      2'h1: s_nxt.drop = i_dest_congested ? 4'h1 : 4'h0;
      2'h2: s_nxt.drop = i_dest_congested ? 4'h3 : 4'h0;
      2'h3: s_nxt.drop = i_dest_congested ? 4'h7 : 4'h0;
    endcase
  end

  // ==========================================================
  // Registers and schedule storage
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      s_r <= '0;
      for (int q = 0; q < 4; q++) begin
        s_r.weight[q]     <= egress_sched_pkg::WEIGHT_RST;
        s_r.high_mark[q]  <= egress_sched_pkg::HIGH_MARK_RST;
        s_r.low_mark[q]   <= egress_sched_pkg::LOW_MARK_RST;
        s_r.increment[q]  <= egress_sched_pkg::INCREMENT_RST;
        s_r.sched_mode[q] <= egress_sched_pkg::SCHED_MODE_RST;
      end
    end else if (i_clk_en) begin
      s_r <= s_nxt;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_clk_en && wr && !s_r.ready &&
        ridx == egress_sched_pkg::GATE_ENTRY_IDX) begin
      entry_mem[s_r.eidx] <= pwdata;
    end
  end

  // ==========================================================
  // Outputs
  assign prdata         = s_r.rdata;
  assign pready         = s_r.ready;
  assign pslverr        = s_r.err && s_r.ready;
  assign o_tx_valid     = s_r.tx_valid;
  assign o_tx_queue     = s_r.tx_q;
  assign o_drop_prio    = s_r.drop;
  assign o_flow_control = s_r.fc;
  assign o_gate_open    = (s_r.gstate == egress_sched_pkg::EV_OPEN);

endmodule : port_egress_queue_scheduler

/* test/egress_sched_assertions.sv */
// Port-level checker for the egress queue scheduler
`timescale 1ns/1ns
module egress_sched_assertions (
  // Clock and reset
  input wire logic       i_core_clk,
  input wire logic       i_nrst,
  // APB answer
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  // Transmit side
  input wire logic [3:0] i_queue_nonempty,
  input wire logic       i_tx_done,
  input wire logic       o_tx_valid,
  input wire logic [1:0] o_tx_queue,
  // Congestion policy
  input wire logic       i_dest_congested,
  input wire logic [3:0] o_drop_prio,
  input wire logic       o_flow_control
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  logic       busy_r;
  logic [3:0] ne_r;
  always_ff @(posedge i_core_clk) begin
    busy_r <= !i_nrst ? 1'b0 : o_tx_valid ? 1'b1 : i_tx_done ? 1'b0 : busy_r;
    ne_r   <= i_queue_nonempty;
  end
  // ==========================================================
  // APB answer timing
  property p_one_wait;
    $rose(penable) && psel |=> pready;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("no answer after wait");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
  property p_err_with_ready;
    pslverr |-> pready && psel && penable;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("lone err");
  // ==========================================================
  // Grants
  property p_grant_pulse;
    o_tx_valid |=> !o_tx_valid;
  endproperty
  a_grant_pulse: assert property (p_grant_pulse) else $error("grant held");
  property p_no_grant_busy;
    o_tx_valid |-> !busy_r;
  endproperty
  a_no_grant_busy: assert property (p_no_grant_busy)
    else $error("grant while busy");
  property p_grant_nonempty;
    o_tx_valid |-> ne_r[o_tx_queue];
  endproperty
  a_grant_nonempty: assert property (p_grant_nonempty)
    else $error("empty queue granted");
  // ==========================================================
  // Congestion outputs
  property p_drop_shape;
    o_drop_prio inside {4'h0, 4'h1, 4'h3, 4'h7};
  endproperty
  a_drop_shape: assert property (p_drop_shape) else $error("bad drop set");
  property p_fc_no_drop;
    o_flow_control |-> o_drop_prio == 4'h0;
  endproperty
  a_fc_no_drop: assert property (p_fc_no_drop) else $error("fc with drop");
  property p_calm;
    !i_dest_congested [*3] |-> o_drop_prio == 4'h0 && !o_flow_control;
  endproperty
  a_calm: assert property (p_calm) else $error("action without congestion");
  c_err:  cover property (pslverr);
  c_fc:   cover property (o_flow_control);
  c_drop: cover property (o_drop_prio == 4'h7);
  c_q3:   cover property (o_tx_valid && o_tx_queue == 2'h3);
endmodule : egress_sched_assertions

bind port_egress_queue_scheduler egress_sched_assertions
  u_egress_sched_assertions (
  .i_core_clk(i_core_clk), .i_nrst(i_nrst), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr),
  .i_queue_nonempty(i_queue_nonempty), .i_tx_done(i_tx_done),
  .o_tx_valid(o_tx_valid), .o_tx_queue(o_tx_queue),
  .i_dest_congested(i_dest_congested), .o_drop_prio(o_drop_prio),
  .o_flow_control(o_flow_control));

/* test/port_egress_queue_scheduler_tb.sv */
// Self-checking bench for the egress queue scheduler
`timescale 1ns/1ns
module port_egress_queue_scheduler_tb;
  logic        core_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
  logic [13:0] paddr = 14'h0000;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic        pready, pslverr, tx_ready, tx_done, tx_valid, fc, gopen;
  logic        slow = 0, cong = 0;
  logic [3:0]  ne = 4'h0, gated = 4'h0, ct = 4'h0, drop;
  logic [15:0] tx_bytes;
  logic [1:0]  tx_queue;
  int          n_mismatch = 0, num_checks = 0;
  int          wt[4] = '{2, 3, 4, 5};
  logic [1:0]  gq[$];
  always #50 core_clk = ~core_clk;
  port_egress_queue_scheduler #(.SECOND_CYCLES(50)) u_port_egress_queue_scheduler (
    .i_core_clk(core_clk), .i_nrst(nrst), .i_clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .i_queue_nonempty(ne), .i_queue_gated(gated),
    .i_queue_cut_through(ct), .i_queue_count_sel(2'h0),
    .i_tx_ready(tx_ready), .i_tx_done(tx_done), .i_tx_bytes(tx_bytes),
    .o_tx_valid(tx_valid), .o_tx_queue(tx_queue), .i_pps(1'b0),
    .i_ref_crossed(1'b0), .i_dest_congested(cong), .o_drop_prio(drop),
    .o_flow_control(fc), .o_gate_open(gopen));
  tx_mac_model u_tx_mac_model (.i_core_clk(core_clk), .i_slow(slow),
    .i_tx_valid(tx_valid), .o_tx_ready(tx_ready), .o_tx_done(tx_done),
    .o_tx_bytes(tx_bytes));
  always @(posedge core_clk) if (tx_valid === 1'b1) gq.push_back(tx_queue);
  // ==========================================================
  // Shared tasks
  task automatic print_verdict();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] idx,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic err);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
    if (n >= 50) begin
      n_mismatch++;
      print_verdict();
    end
  endtask : apb
  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, idx, d, r, e);
  endtask : wr
  task automatic rd(input logic [11:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, idx, 32'h0000_0000, r, e);
    chk(r, exp);
  endtask : rd
  task automatic collect(input int cnt);
    int n;
    n = 0;
    while (gq.size() < cnt && n < 3000) begin
      @(posedge core_clk);
      n++;
    end
    ne <= 4'h0;
    repeat (20) @(posedge core_clk);
    if (n >= 3000) begin
      n_mismatch++;
      print_verdict();
    end
  endtask : collect
  // ==========================================================
  // Scenarios
  task automatic t_reset_and_index();
    logic [31:0] r;
    logic        e;
    for (int q = 0; q < 4; q++) begin
      wr(egress_sched_pkg::QUEUE_INDEX_IDX, 32'(q));
      rd(egress_sched_pkg::QUEUE_WEIGHT_IDX, 32'h0000_0001);
      rd(egress_sched_pkg::CREDIT_HIGH_MARK_IDX, 32'h0000_0534);
      rd(egress_sched_pkg::CREDIT_LOW_MARK_IDX, 32'h0000_05f2);
      rd(egress_sched_pkg::CREDIT_INCREMENT_IDX, 32'h0000_2000);
      wr(egress_sched_pkg::QUEUE_WEIGHT_IDX, 32'h0000_0080 | 32'(wt[q]));
      wr(egress_sched_pkg::CREDIT_HIGH_MARK_IDX, 32'h0000_1000 + 32'(q));
    end
    for (int q = 3; q >= 0; q--) begin
      wr(egress_sched_pkg::QUEUE_INDEX_IDX, 32'(q));
      rd(egress_sched_pkg::QUEUE_WEIGHT_IDX, 32'(wt[q]));
      rd(egress_sched_pkg::CREDIT_HIGH_MARK_IDX, 32'h0000_1000 + 32'(q));
    end
    rd(egress_sched_pkg::GATE_SHAPER_CTRL_IDX, 32'h0000_0000);
    apb(1'b1, 12'hfff, 32'h0000_ffff, r, e);
    chk(32'(e), 32'h0000_0001);
  endtask : t_reset_and_index
  task automatic t_rotation();
    int run;
    int sw;
    run = 1;
    sw = 0;
    gq.delete();
    ne <= 4'b0011;
    collect(16);
    for (int k = 1; k < gq.size(); k++) begin
      if (gq[k] == gq[k-1]) run++;
      else begin
        sw++;
        run = 1;
      end
      if (run > wt[gq[k]]) chk(32'(run), 32'(wt[gq[k]]));
    end
    chk(32'(sw > 2), 32'h0000_0001);
    wr(egress_sched_pkg::PORT_STATUS_IDX, 32'h0000_0010);
    gq.delete();
    ne <= 4'b0011;
    collect(4);
    for (int k = 0; k < 4; k++) chk(32'(gq[k]), 32'h0000_0000);
    wr(egress_sched_pkg::PORT_STATUS_IDX, 32'h0000_0000);
  endtask : t_rotation
  task automatic t_strict();
    slow <= 1'b1;
    wr(egress_sched_pkg::QUEUE_INDEX_IDX, 32'h0000_0000);
    wr(egress_sched_pkg::QUEUE_MODE_IDX, 32'h0000_0000);
    gq.delete();
    ne <= 4'b1010;
    collect(6);
    for (int k = 0; k < 6; k++) chk(32'(gq[k]), 32'h0000_0003);
    ct <= 4'b1000;
    gq.delete();
    ne <= 4'b1010;
    collect(3);
    for (int k = 0; k < 3; k++) chk(32'(gq[k]), 32'h0000_0001);
    wr(egress_sched_pkg::GATE_SHAPER_CTRL_IDX, 32'h0000_0080);
    gq.delete();
    ne <= 4'b1010;
    collect(3);
    for (int k = 0; k < 3; k++) chk(32'(gq[k]), 32'h0000_0003);
    wr(egress_sched_pkg::GATE_SHAPER_CTRL_IDX, 32'h0000_0000);
    ct <= 4'h0;
    wr(egress_sched_pkg::QUEUE_MODE_IDX, 32'h0000_0080);
    slow <= 1'b0;
  endtask : t_strict
  task automatic t_drop();
    for (int m = 0; m < 4; m++) begin
      wr(egress_sched_pkg::CONGESTION_DROP_IDX, 32'(m));
      cong <= 1'b1;
      repeat (3) @(posedge core_clk);
      chk(32'(drop), (32'h0000_0001 << m) - 1);
      chk(32'(fc), 32'(m == 0));
      cong <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
  endtask : t_drop
  task automatic t_gate();
    logic [31:0] ev[4];
    int          hi;
    int          lo;
    int          ng;
    logic        was_open;
    ev = '{32'h4000_0014, 32'h2000_0005, 32'h0000_0014, 32'he000_0000};
    hi = 0;
    lo = 0;
    for (int k = 0; k < 4; k++) begin
      wr(egress_sched_pkg::GATE_ENTRY_INDEX_IDX, 32'(k));
      wr(egress_sched_pkg::GATE_ENTRY_IDX, ev[k]);
    end
    wr(egress_sched_pkg::GATE_ENTRY_INDEX_IDX, 32'h0000_0001);
    rd(egress_sched_pkg::GATE_ENTRY_IDX, ev[1]);
    wr(egress_sched_pkg::QUEUE_MODE_IDX, 32'h0000_00a0);
    // Reference 00 last so the schedule is left running
    for (int k = 3; k >= 0; k--) begin
      wr(egress_sched_pkg::GATE_SHAPER_CTRL_IDX, 32'h0000_00c0 | 32'(k));
      rd(egress_sched_pkg::GATE_SHAPER_CTRL_IDX, 32'h0000_00c0 | 32'(k));
    end
    ng = 0;
    gated <= 4'h1;
    ne <= 4'h1;
    was_open = gopen;
    repeat (300) begin
      @(posedge core_clk);
      if (gopen === 1'b1) hi++;
      if (gopen === 1'b0) lo++;
      // Grant decided on the gate state one edge earlier
      if (tx_valid === 1'b1) begin
        ng++;
        chk(32'(was_open), 32'h0000_0001);
      end
      was_open = gopen;
    end
    chk(32'(hi > 0 && lo > 0), 32'h0000_0001);
    chk(32'(ng > 0), 32'h0000_0001);
    ne <= 4'h0;
    gated <= 4'h0;
  endtask : t_gate
  initial begin
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    t_reset_and_index();
    t_rotation();
    t_strict();
    t_drop();
    t_gate();
    print_verdict();
  end
endmodule : port_egress_queue_scheduler_tb

/* test/tx_mac_model.sv */
// Behavioural transmit MAC facing the scheduler grants
`timescale 1ns/1ns
module tx_mac_model (
  // Clock and pacing
  input  wire logic  i_core_clk,
  input  wire logic  i_slow,
  // Grant in
  input  wire logic  i_tx_valid,
  // Completion out
  output logic       o_tx_ready,
  output logic       o_tx_done,
  output logic [15:0] o_tx_bytes
);
  int          cnt;
  logic [15:0] len;
  initial begin
    cnt        = 0;
    len        = 16'h0040;
    o_tx_ready = 1'b1;
    o_tx_done  = 1'b0;
    o_tx_bytes = 16'hffbf;
  end
  // Length only valid with done; otherwise show garbage, not stale data
  always @(posedge i_core_clk) begin
    o_tx_done  <= 1'b0;
    o_tx_bytes <= ~len;
    if (i_tx_valid === 1'b1) begin
      o_tx_ready <= 1'b0;
      cnt        <= i_slow ? 9 : 2;
    end else if (cnt == 1) begin
      o_tx_done  <= 1'b1;
      o_tx_bytes <= len;
      o_tx_ready <= 1'b1;
      len        <= len + 16'h0010;
      cnt        <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule : tx_mac_model
